// ---- core/pmfc_cfg.svh ----
// command codes, field positions, reset values and timing counts
`ifndef PMFC_CFG_SVH
`define PMFC_CFG_SVH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define PMFC_CMD_ONOFF 8'h02
`define PMFC_CMD_CLEAR 8'h03
`define PMFC_CMD_PHASE 8'h04

// ------------------------------------------------------------
// enable source configuration fields
// ------------------------------------------------------------
`define PMFC_PU_BIT 4
`define PMFC_CMD_BIT 3
`define PMFC_CP_BIT 2
`define PMFC_POL_BIT 1
`define PMFC_DLY_BIT 0
`define PMFC_CFG_RSVD 3'h0
`define PMFC_CFG_RST 5'h1c

// ------------------------------------------------------------
// phase selector and status
// ------------------------------------------------------------
`define PMFC_PHASE_LAST 8'h03
`define PMFC_PHASE_ALL 8'hff
`define PMFC_PHASE_RST 8'hff
`define PMFC_PHASE_CTRL 8'h00
`define PMFC_CML_BIT 7

// ------------------------------------------------------------
// turn-off profile timing
// ------------------------------------------------------------
`define PMFC_CLK_PERIOD_NS 25
`define PMFC_TOFF_DELAY_NS 1000
`define PMFC_TOFF_FALL_NS 1000
`define PMFC_TOFF_DELAY_CYC \
    ((`PMFC_TOFF_DELAY_NS + `PMFC_CLK_PERIOD_NS - 1) / `PMFC_CLK_PERIOD_NS)
`define PMFC_TOFF_FALL_CYC \
    ((`PMFC_TOFF_FALL_NS + `PMFC_CLK_PERIOD_NS - 1) / `PMFC_CLK_PERIOD_NS)

`endif

// ---- core/pmfc_pkg.sv ----
// types shared by the command block and its alert logic
package pmfc_pkg;

    localparam int NPH = 4;
    localparam int NSTS = 8;
    localparam int NFLT = 7;

    typedef logic [7:0] pmfc_byte_t;
    typedef logic [NPH*NSTS-1:0] pmfc_sts_t;
    typedef logic [NPH*NFLT-1:0] pmfc_flt_t;

    typedef enum logic [1:0] {
        PW_OFF = 2'b00,
        PW_ON = 2'b01,
        PW_DLY = 2'b10,
        PW_FALL = 2'b11
    } pmfc_pwr_t;

    typedef struct packed {
        pmfc_pwr_t state;
        logic [4:0] cfg;
        pmfc_byte_t phase;
        pmfc_byte_t own;
        pmfc_sts_t sts;
        logic [15:0] cnt;
        logic convOn;
        logic ramp;
        logic rspValid;
        pmfc_byte_t rspData;
        logic rspErr;
    } pmfc_core_t;

    typedef struct packed {
        logic alertN;
        logic araAck;
    } pmfc_alert_t;

endpackage : pmfc_pkg

// ---- core/pmfc_if.sv ----
// link between command core and alert logic
`timescale 1ns/1ps
interface pmfc_if;
    pmfc_pkg::pmfc_sts_t stsRise;
    logic clrAny;
    logic araQuery;
    logic alertN;
    logic araAck;

    modport core (output stsRise, output clrAny, output araQuery, input alertN, input araAck);
    modport alert (input stsRise, input clrAny, input araQuery, output alertN, output araAck);
endinterface : pmfc_if

// ---- core/pmfc_alert.sv ----
// alert line driver with alert-response answer
`timescale 1ns/1ps
module pmfc_alert (
    input wire logic core_clk,
    input wire logic rst_n,
    pmfc_if.alert bus
);
    import pmfc_pkg::*;

    pmfc_alert_t a_ff;
    pmfc_alert_t nxt_a;

    // ------------------------------------------------------------
    // alert state
    // ------------------------------------------------------------
    // a new status bit always wins over a release in the same cycle
    always_comb begin
        nxt_a = a_ff;
        nxt_a.araAck = bus.araQuery & ~a_ff.alertN;
        if (nxt_a.araAck || bus.clrAny) begin
            nxt_a.alertN = 1'b1;
        end
        // bits already set and not being cleared give no rise, so they cannot re-trigger
        if (|bus.stsRise) begin
            nxt_a.alertN = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            a_ff <= '{alertN: 1'b1, araAck: 1'b0};
        end else begin
            a_ff <= nxt_a;
        end
    end

    assign bus.alertN = a_ff.alertN;
    assign bus.araAck = a_ff.araAck;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_clr_release;
        bus.clrAny && !(|bus.stsRise) |=> bus.alertN;
    endproperty
    a_clr_release: assert property (p_clr_release)
        else $error("alert not released by fault clear");

    property p_ara_answer;
        bus.araQuery && !bus.alertN && !(|bus.stsRise) |=> bus.araAck && bus.alertN;
    endproperty
    a_ara_answer: assert property (p_ara_answer)
        else $error("alert response not answered");

    property p_new_fault;
        |bus.stsRise |=> !bus.alertN;
    endproperty
    a_new_fault: assert property (p_new_fault)
        else $error("new fault did not assert alert");

    property p_no_spurious;
        bus.alertN && !(|bus.stsRise) |=> bus.alertN;
    endproperty
    a_no_spurious: assert property (p_no_spurious)
        else $error("alert asserted without a new fault");

endmodule : pmfc_alert

// ---- core/pmfc_cmd.sv ----
// enable source, fault clear and phase selector command handling
`timescale 1ns/1ps
`include "pmfc_cfg.svh"

// Contract
// - enable config bits 7:5 read zero
// - power-up bit clear: start on input power
// - command bit governs operation on/off bit
// - pin bit governs control pin participation
// - polarity bit: low active or high active
// - delay bit clear: regulate, then ramp down
// - delay bit set: stop at once on pin
// - control pin is enable/lockout pin
// - invalid enable config write flags status
// - fault clear is data-less write only
// - clear selected phase status, all for FFh
// - fault clear releases the alert line
// - fault clear never restarts latched unit
// - persisting fault sets bit and alerts again
// - alert response releases alert, keeps status
// - only faults after answer re-assert alert
// - phase selector steers phased commands
// - each phase keeps its own storage
// - grounded strap is phase zero, else position
// - phases 00h-03h, FFh all, rest invalid
// - operation bit 7 acts only when obeyed
module pmfc_cmd (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmdValid,
    input wire logic cmdWrite,
    input wire logic cmdHasData,
    input wire pmfc_pkg::pmfc_byte_t cmdCode,
    input wire pmfc_pkg::pmfc_byte_t cmdData,
    input wire logic opOnOff,
    input wire logic inputPowerOk,
    input wire logic latchedOff,
    input wire logic enableLockoutPin,
    input wire logic followerStrapPin,
    input wire logic [1:0] positionA,
    input wire pmfc_pkg::pmfc_flt_t faultIn,
    input wire logic araQuery,
    output logic rspValid,
    output pmfc_pkg::pmfc_byte_t rspData,
    output logic rspErr,
    output logic convEnable,
    output logic rampDown,
    output pmfc_pkg::pmfc_byte_t ownPhase,
    output pmfc_pkg::pmfc_sts_t statusBits,
    output logic smbAlertN,
    output logic araAck
);
    import pmfc_pkg::*;

    pmfc_core_t s_ff;
    pmfc_core_t nxt_s;
    pmfc_if bus ();

    logic pinAct;
    logic wantOn;
    logic pinOff;
    logic clrEv;
    logic cmlEv;
    logic cfgWr;
    logic phWr;
    logic rErr;
    pmfc_byte_t rData;
    logic [NPH-1:0] selPh;
    pmfc_sts_t setV;
    pmfc_sts_t clrV;

    // ------------------------------------------------------------
    // control sources
    // ------------------------------------------------------------
    // the enable/lockout pin, corrected for its configured sense
    assign pinAct = s_ff.cfg[`PMFC_POL_BIT] ? enableLockoutPin : ~enableLockoutPin;

    // every enabled source must agree before conversion may run
    always_comb begin
        wantOn = inputPowerOk & ~latchedOff;
        pinOff = 1'b0;
        if (s_ff.cfg[`PMFC_PU_BIT]) begin
            if (s_ff.cfg[`PMFC_CMD_BIT] && !opOnOff) begin
                wantOn = 1'b0;
            end
            // pin is only the cause when nothing else forces off
            if (s_ff.cfg[`PMFC_CP_BIT] && !pinAct) begin
                pinOff = wantOn;
                wantOn = 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    // reads answer from held state; bad data only flags status
    always_comb begin
        clrEv = 1'b0;
        cmlEv = 1'b0;
        cfgWr = 1'b0;
        phWr = 1'b0;
        rErr = 1'b0;
        rData = 8'h00;
        if (cmdValid) begin
            case (cmdCode)
                `PMFC_CMD_ONOFF: begin
                    if (!cmdWrite) begin
                        rData = {`PMFC_CFG_RSVD, s_ff.cfg};
                    end else if (cmdHasData && cmdData[7:5] == `PMFC_CFG_RSVD) begin
                        cfgWr = 1'b1;
                    end else begin
                        rErr = 1'b1;
                        cmlEv = 1'b1;
                    end
                end
                `PMFC_CMD_CLEAR: begin
                    if (cmdWrite && !cmdHasData) begin
                        clrEv = 1'b1;
                    end else begin
                        rErr = 1'b1;
                        cmlEv = 1'b1;
                    end
                end
                `PMFC_CMD_PHASE: begin
                    if (!cmdWrite) begin
                        rData = s_ff.phase;
                    end else if (cmdHasData && (cmdData <= `PMFC_PHASE_LAST ||
                                                cmdData == `PMFC_PHASE_ALL)) begin
                        phWr = 1'b1;
                    end else begin
                        rErr = 1'b1;
                        cmlEv = 1'b1;
                    end
                end
                default: begin
                    rErr = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // per-phase status storage
    // ------------------------------------------------------------
    // each phase has its own status byte; faults are levels, so a
    // persisting one lands again in the very cycle it is cleared
    for (genvar g = 0; g < NPH; g++) begin : g_ph
        assign selPh[g] = (s_ff.phase == `PMFC_PHASE_ALL) || (s_ff.phase == 8'(g));
        assign setV[g*NSTS +: NSTS] = {cmlEv & selPh[g], faultIn[g*NFLT +: NFLT]};
        assign clrV[g*NSTS +: NSTS] = {NSTS{clrEv & selPh[g]}};
    end

    // new bits only: a bit that survives a clear still counts as new
    assign bus.stsRise = setV & ~(s_ff.sts & ~clrV);
    assign bus.clrAny = clrEv;
    assign bus.araQuery = araQuery;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rspValid = cmdValid;
        nxt_s.rspData = rData;
        nxt_s.rspErr = rErr;
        if (cfgWr) begin
            nxt_s.cfg = cmdData[4:0];
        end
        if (phWr) begin
            nxt_s.phase = cmdData;
        end
        // strap is sampled every cycle, so it settles after reset
        nxt_s.own = followerStrapPin ? {6'h00, positionA} : `PMFC_PHASE_CTRL;
        // set wins over clear; an answered alert leaves status alone
        nxt_s.sts = (s_ff.sts & ~clrV) | setV;
        case (s_ff.state)
            PW_OFF: begin
                // clearing faults does not touch latchedOff
                if (wantOn) begin
                    nxt_s.state = PW_ON;
                end
            end
            PW_ON: begin
                if (!wantOn) begin
                    if (pinOff && !s_ff.cfg[`PMFC_DLY_BIT]) begin
                        nxt_s.state = PW_DLY;
                        nxt_s.cnt = 16'(`PMFC_TOFF_DELAY_CYC - 1);
                    end else begin
                        nxt_s.state = PW_OFF;
                    end
                end
            end
            PW_DLY: begin
                if (!inputPowerOk || latchedOff) begin
                    nxt_s.state = PW_OFF;
                end else if (wantOn) begin
                    nxt_s.state = PW_ON;
                end else if (s_ff.cnt == 16'h0000) begin
                    nxt_s.state = PW_FALL;
                    nxt_s.cnt = 16'(`PMFC_TOFF_FALL_CYC - 1);
                end else begin
                    nxt_s.cnt = s_ff.cnt - 16'h0001;
                end
            end
            PW_FALL: begin
                // no restart during a ramp; it ends at count zero, or early on input power loss or latch-off
                if (!inputPowerOk || latchedOff || s_ff.cnt == 16'h0000) begin
                    nxt_s.state = PW_OFF;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 16'h0001;
                end
            end
            default: begin
                nxt_s.state = PW_OFF;
            end
        endcase
        nxt_s.convOn = (nxt_s.state != PW_OFF);
        nxt_s.ramp = (nxt_s.state == PW_FALL);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '{state: PW_OFF, cfg: `PMFC_CFG_RST, phase: `PMFC_PHASE_RST,
                      default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // alert line lives in its own small module
    pmfc_alert u_alert (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .bus(bus.alert)
    );

    // outputs, all straight from flip-flops
    assign rspValid = s_ff.rspValid;
    assign rspData = s_ff.rspData;
    assign rspErr = s_ff.rspErr;
    assign convEnable = s_ff.convOn;
    assign rampDown = s_ff.ramp;
    assign ownPhase = s_ff.own;
    assign statusBits = s_ff.sts;
    assign smbAlertN = bus.alertN;
    assign araAck = bus.araAck;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_cfg_read;
        cmdValid && !cmdWrite && cmdCode == `PMFC_CMD_ONOFF
            |=> rspValid && !rspErr && rspData[7:5] == 3'h0;
    endproperty
    a_cfg_read: assert property (p_cfg_read)
        else $error("enable config read returned set upper bits");

    property p_pu_clear;
        s_ff.state == PW_OFF && !s_ff.cfg[`PMFC_PU_BIT] && inputPowerOk && !latchedOff
            |=> convEnable;
    endproperty
    a_pu_clear: assert property (p_pu_clear)
        else $error("no start on input power with gate bit clear");

    property p_cmd_ignored;
        s_ff.state == PW_OFF && s_ff.cfg[4:2] == 3'b101 && pinAct && !opOnOff &&
            inputPowerOk && !latchedOff |=> convEnable;
    endproperty
    a_cmd_ignored: assert property (p_cmd_ignored)
        else $error("operation bit not ignored");

    property p_pin_ignored;
        s_ff.state == PW_OFF && s_ff.cfg[4:2] == 3'b110 && opOnOff &&
            inputPowerOk && !latchedOff |=> convEnable;
    endproperty
    a_pin_ignored: assert property (p_pin_ignored)
        else $error("control pin not ignored");

    property p_soft_off;
        s_ff.state == PW_ON && !wantOn && pinOff && !s_ff.cfg[`PMFC_DLY_BIT]
            |=> convEnable && !rampDown;
    endproperty
    a_soft_off: assert property (p_soft_off)
        else $error("pin off did not keep regulating");

    property p_fall_start;
        s_ff.state == PW_DLY && s_ff.cnt == 16'h0000 && !wantOn && inputPowerOk &&
            !latchedOff |=> convEnable && rampDown;
    endproperty
    a_fall_start: assert property (p_fall_start)
        else $error("ramp down did not follow turn-off delay");

    property p_hard_off;
        s_ff.state == PW_ON && s_ff.cfg[`PMFC_PU_BIT] && s_ff.cfg[`PMFC_CP_BIT] &&
            s_ff.cfg[`PMFC_DLY_BIT] && !pinAct |=> !convEnable;
    endproperty
    a_hard_off: assert property (p_hard_off)
        else $error("pin off with delay bit set did not stop at once");

    property p_cfg_invalid;
        cmdValid && cmdWrite && cmdCode == `PMFC_CMD_ONOFF && cmdData[7:5] != 3'h0
            |=> rspErr && $stable(s_ff.cfg);
    endproperty
    a_cfg_invalid: assert property (p_cfg_invalid)
        else $error("invalid enable config accepted");

    property p_clear_read;
        cmdValid && !cmdWrite && cmdCode == `PMFC_CMD_CLEAR |=> rspValid && rspErr;
    endproperty
    a_clear_read: assert property (p_clear_read)
        else $error("read of fault clear not refused");

    property p_clear_all;
        cmdValid && cmdWrite && !cmdHasData && cmdCode == `PMFC_CMD_CLEAR &&
            s_ff.phase == `PMFC_PHASE_ALL && faultIn == '0 |=> statusBits == '0;
    endproperty
    a_clear_all: assert property (p_clear_all)
        else $error("fault clear left status bits set");

    property p_latched;
        latchedOff |=> !convEnable;
    endproperty
    a_latched: assert property (p_latched)
        else $error("latched unit kept or resumed conversion");

    property p_phase_write;
        cmdValid && cmdWrite && cmdHasData && cmdCode == `PMFC_CMD_PHASE &&
            cmdData <= `PMFC_PHASE_LAST |=> s_ff.phase == $past(cmdData) && !rspErr;
    endproperty
    a_phase_write: assert property (p_phase_write)
        else $error("phase selector did not take valid value");

    property p_phase_bad;
        cmdValid && cmdWrite && cmdCode == `PMFC_CMD_PHASE && cmdData > `PMFC_PHASE_LAST &&
            cmdData != `PMFC_PHASE_ALL |=> rspErr && $stable(s_ff.phase);
    endproperty
    a_phase_bad: assert property (p_phase_bad)
        else $error("invalid phase value accepted");

    property p_ctrl_phase;
        !followerStrapPin |=> ownPhase == 8'h00;
    endproperty
    a_ctrl_phase: assert property (p_ctrl_phase)
        else $error("loop controller not phase zero");

    property p_op_off;
        s_ff.state == PW_ON && s_ff.cfg[`PMFC_PU_BIT] && s_ff.cfg[`PMFC_CMD_BIT] && !opOnOff
            |=> !convEnable;
    endproperty
    a_op_off: assert property (p_op_off)
        else $error("operation off bit not obeyed");

endmodule : pmfc_cmd

// ---- dv/pmfc_host.sv ----
// host controller model issuing decoded bus commands and alert queries
`timescale 1ns/1ps
module pmfc_host (
    input wire logic core_clk,
    input wire logic rspValid,
    input wire pmfc_pkg::pmfc_byte_t rspData,
    input wire logic rspErr,
    input wire logic araAck,
    output logic cmdValid,
    output logic cmdWrite,
    output logic cmdHasData,
    output pmfc_pkg::pmfc_byte_t cmdCode,
    output pmfc_pkg::pmfc_byte_t cmdData,
    output logic araQuery
);
    import pmfc_pkg::*;

    // bus idle from time zero
    initial begin
        cmdValid = 1'b0;
        cmdWrite = 1'b0;
        cmdHasData = 1'b0;
        cmdCode = 8'h00;
        cmdData = 8'h00;
        araQuery = 1'b0;
    end

    // one command pulse, answer taken at the next edge; the data byte flag goes out as the caller gives it
    task xfer(input logic w, input logic hd, input pmfc_byte_t c, input pmfc_byte_t d,
              output logic v, output logic e, output pmfc_byte_t r);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdWrite <= w;
        cmdHasData <= hd;
        cmdCode <= c;
        cmdData <= d;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        cmdData <= ~d; // data not held past the pulse
        #1;
        v = rspValid;
        e = rspErr;
        r = rspData;
    endtask : xfer

    // alert response query, one pulse
    task query(output logic ack);
        @(posedge core_clk);
        araQuery <= 1'b1;
        @(posedge core_clk);
        araQuery <= 1'b0;
        #1;
        ack = araAck;
    endtask : query
endmodule : pmfc_host

// ---- dv/tb.sv ----
// self-checking bench for the command block
`timescale 1ns/1ps
`include "pmfc_cfg.svh"
module tb;
    import pmfc_pkg::*;
    logic core_clk, rst_n, opOnOff, inputPowerOk, latchedOff, enableLockoutPin;
    logic followerStrapPin, araQuery, cmdValid, cmdWrite, cmdHasData, rspValid, rspErr;
    logic convEnable, rampDown, smbAlertN, araAck, v, e, mAlertN;
    logic [1:0] positionA;
    logic [4:0] mCfg;
    logic [31:0] rnd;
    pmfc_byte_t cmdCode, cmdData, rspData, ownPhase, r, mPhase;
    pmfc_flt_t faultIn;
    pmfc_sts_t statusBits, mSts;
    int fails, checkCount, cycles, seed, nDly, nRamp;

    pmfc_cmd DUT (.core_clk(core_clk), .rst_n(rst_n), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdHasData(cmdHasData), .cmdCode(cmdCode), .cmdData(cmdData), .opOnOff(opOnOff),
        .inputPowerOk(inputPowerOk), .latchedOff(latchedOff), .enableLockoutPin(enableLockoutPin),
        .followerStrapPin(followerStrapPin), .positionA(positionA), .faultIn(faultIn),
        .araQuery(araQuery), .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr),
        .convEnable(convEnable), .rampDown(rampDown), .ownPhase(ownPhase),
        .statusBits(statusBits), .smbAlertN(smbAlertN), .araAck(araAck));
    pmfc_host host (.core_clk(core_clk), .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr),
        .araAck(araAck), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdHasData(cmdHasData),
        .cmdCode(cmdCode), .cmdData(cmdData), .araQuery(araQuery));

    // ------------------------------------------------------------
    // reference model helpers
    // ------------------------------------------------------------
    function automatic pmfc_sts_t fltSts(pmfc_flt_t f);
        pmfc_sts_t s;
        s = '0;
        for (int p = 0; p < NPH; p++)
            s[8*p +: 7] = f[7*p +: 7];
        return s;
    endfunction : fltSts
    // bytes of the phases the selector addresses
    function automatic pmfc_sts_t selMask();
        return (mPhase == 8'hff) ? '1 : pmfc_sts_t'(32'hff) << (8 * int'(mPhase));
    endfunction : selMask
    function automatic logic wantOn(logic [4:0] f);
        logic pinAct;
        pinAct = f[1] ? enableLockoutPin : !enableLockoutPin;
        return inputPowerOk && !latchedOff && (!f[4] || ((!f[3] || opOnOff) && (!f[2] || pinAct)));
    endfunction : wantOn

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one command through the host, model updated alongside
    task cmd(input logic w, input logic hd, input pmfc_byte_t code, input pmfc_byte_t d);
        logic bad;
        pmfc_byte_t expR;
        pmfc_sts_t fm;
        expR = 8'h00;
        fm = selMask() & {NPH{8'h80}};
        case (code)
            8'h02: bad = w && !(hd && d[7:5] == 3'h0);
            8'h03: bad = !w || hd;
            8'h04: bad = w && !(hd && (d <= 8'h03 || d == 8'hff));
            default: bad = 1'b1;
        endcase
        host.xfer(w, hd, code, d, v, e, r);
        if (!bad && !w)
            expR = (code == 8'h02) ? {3'h0, mCfg} : mPhase;
        if (!bad && w && code == 8'h02)
            mCfg = d[4:0];
        if (!bad && w && code == 8'h04)
            mPhase = d;
        if (!bad && code == 8'h03) begin
            mSts = (mSts & ~selMask()) | (fltSts(faultIn) & selMask());
            mAlertN = ((fltSts(faultIn) & selMask()) == '0);
        end
        if (bad && code inside {8'h02, 8'h03, 8'h04}) begin
            if ((mSts & fm) != fm)
                mAlertN = 1'b0;
            mSts = mSts | fm;
        end
        chk(v, 1'b1);
        chk(e, bad);
        chk(r, expR);
        chk(statusBits, mSts);
        @(posedge core_clk);
        #1;
        chk(smbAlertN, mAlertN);
    endtask : cmd

    // fault levels applied; only bits not yet set raise the alert
    task fault(input pmfc_flt_t f);
        @(posedge core_clk);
        faultIn <= f;
        repeat (2) @(posedge core_clk);
        #1;
        if ((fltSts(f) & ~mSts) != '0)
            mAlertN = 1'b0;
        mSts = mSts | fltSts(f);
        chk(statusBits, mSts);
        chk(smbAlertN, mAlertN);
    endtask : fault

    task ara();
        host.query(v);
        chk(v, !mAlertN);
        mAlertN = 1'b1;
        chk(smbAlertN, 1'b1);
        chk(statusBits, mSts);
    endtask : ara

    // wait a few edges, then conversion level against the model
    task settle(input logic expOn);
        repeat (3) @(posedge core_clk);
        #1;
        chk(convEnable, expOn);
    endtask : settle

    task closeOut();
        $display("comparisons %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : closeOut

    // ------------------------------------------------------------
    // clock and hang guard
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            closeOut();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, opOnOff, inputPowerOk, latchedOff, enableLockoutPin, followerStrapPin} = '0;
        positionA = 2'h3;
        faultIn = '0;
        {fails, checkCount, cycles} = '0;
        seed = 28764;
        {mCfg, mPhase, mSts, mAlertN} = {5'(`PMFC_CFG_RST), 8'hff, 32'h0, 1'b1};
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk(ownPhase, 8'h00);
        chk(smbAlertN, 1'b1);
        cmd(1'b0, 1'b0, 8'h02, 8'h00);
        cmd(1'b0, 1'b0, 8'h04, 8'h00);
        for (int p = 0; p < 4; p++) begin
            cmd(1'b1, 1'b1, 8'h04, 8'(p));
            cmd(1'b0, 1'b0, 8'h04, 8'h00);
        end
        cmd(1'b1, 1'b1, 8'h04, 8'h04);
        cmd(1'b1, 1'b1, 8'h04, 8'hfe);
        cmd(1'b1, 1'b0, 8'h04, 8'h00);
        cmd(1'b1, 1'b0, 8'h03, 8'h00);
        cmd(1'b0, 1'b0, 8'h03, 8'h00);
        cmd(1'b1, 1'b1, 8'h03, 8'h5a);
        cmd(1'b1, 1'b1, 8'h04, 8'hff);
        cmd(1'b1, 1'b1, 8'h02, 8'he0);
        cmd(1'b1, 1'b0, 8'h02, 8'h00);
        cmd(1'b1, 1'b1, 8'h04, 8'h02);
        cmd(1'b1, 1'b0, 8'h03, 8'h00);
        cmd(1'b1, 1'b1, 8'h10, 8'h00);
        cmd(1'b1, 1'b1, 8'h04, 8'hff);
        cmd(1'b1, 1'b0, 8'h03, 8'h00);
        fault(28'h80);
        ara();
        fault(28'h80);
        fault(28'h81);
        cmd(1'b1, 1'b0, 8'h03, 8'h00);
        fault(28'h0);
        cmd(1'b1, 1'b0, 8'h03, 8'h00);
        // random source combinations, immediate-off profile only
        for (int i = 0; i < 48; i++) begin
            rnd = $random(seed);
            cmd(1'b1, 1'b1, 8'h02, {3'h0, rnd[7:4], 1'b1});
            cmd(1'b0, 1'b0, 8'h02, 8'h00);
            opOnOff <= rnd[8];
            inputPowerOk <= rnd[9] | rnd[10];
            enableLockoutPin <= rnd[11];
            // let the new levels land before the model reads them
            #1;
            settle(wantOn(mCfg));
        end
        {inputPowerOk, latchedOff, enableLockoutPin} <= 3'b111;
        cmd(1'b1, 1'b1, 8'h02, 8'h0d);
        cmd(1'b1, 1'b0, 8'h03, 8'h00);
        settle(1'b0);
        latchedOff <= 1'b0;
        cmd(1'b1, 1'b1, 8'h02, 8'h16);
        settle(1'b1);
        enableLockoutPin <= 1'b0;
        {nDly, nRamp} = '0;
        repeat (100) begin
            @(posedge core_clk);
            #1;
            nDly += int'(convEnable && !rampDown);
            nRamp += int'(rampDown);
        end
        chk(32'(nDly), 32'(`PMFC_TOFF_DELAY_CYC));
        chk(32'(nRamp), 32'(`PMFC_TOFF_FALL_CYC));
        chk(convEnable, 1'b0);
        cmd(1'b1, 1'b1, 8'h02, 8'h17);
        enableLockoutPin <= 1'b1;
        settle(1'b1);
        enableLockoutPin <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk({convEnable, rampDown}, 2'b00);
        followerStrapPin <= 1'b1;
        positionA <= 2'h2;
        repeat (2) @(posedge core_clk);
        #1;
        chk(ownPhase, 8'h02);
        closeOut();
    end
endmodule : tb
